//--- rtl/osd_text_and_four_color_attr.sv
`timescale 1ns/1ns
// What this block does
// R1 - Colour mode bit enables four-colour rendering
// R2 - Four-colour forced off at row start
// R3 - Four-colour merges glyph with neighbour plane
// R4 - Two-bit pixel picks bg, fg, xor 8
// R5 - Even code takes second plane from n+1
// R6 - Odd code uses own glyph twice
// R7 - Foreground decision from first glyph only
// R8 - Colour codes index programmable 4096-colour table
// R9 - Text codes fetched by DMA reads
// R10 - Overlay colour may override teletext colour
// R11 - Fetch starts at programmable text pointer
// R12 - Codes below 80h glyph, else control
// R13 - After control code read one more
// R14 - Software puts one control per character
// R15 - Underline, flash, italics on/off codes
// R16 - Transparent, shadow, end layer, end line
// R17 - Codes 0E-7F drawn from font one/two
// R18 - Control code is colour or set by mode
// R19 - Colour fields fg, bg, white transparent
// R20 - Set fields bits 7-9 and latch
// R21 - Non-latched set applies to one character
module osd_text_and_four_color_attr
  import osd_pkg::*;
#(
  parameter int addr_width = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic row_start,
  input wire logic color_mode_bit,
  input wire logic color_mode_wr,
  input wire logic char_take,
  input wire logic [9:0] ttx_char_code,
  input wire logic [addr_width-1:0] text_pointer,
  input wire logic layer_start,
  input wire logic osd_mode_charset,
  input wire logic font_select,
  output logic dma_req,
  output logic [addr_width-1:0] dma_addr,
  input wire logic dma_ack,
  input wire logic [7:0] dma_data,
  output logic [9:0] osd_char,
  output logic osd_char_valid,
  output logic osd_font,
  output logic underline,
  output logic flash,
  output logic italics,
  output logic transparent,
  output logic shadow,
  output logic white_transp,
  output logic line_end,
  output logic layer_done,
  output logic [9:0] glyph_a_code,
  output logic [9:0] glyph_b_code,
  output logic four_colour,
  input wire logic plane_a,
  input wire logic plane_b,
  input wire logic [3:0] ttx_fg,
  input wire logic [3:0] ttx_bg,
  input wire logic ttx_pix_valid,
  input wire logic osd_pix_valid,
  input wire logic osd_priority,
  input wire logic clut_wr,
  input wire logic [3:0] clut_index,
  input wire logic [clut_colour_bits-1:0] clut_colour,
  output logic [clut_colour_bits-1:0] pix_colour,
  output logic pix_fg
);
  // ==========================================
  // Parameter limits
  // The fetch pointer must be at least one byte wide
  // and no wider than the processor's address space
  if (addr_width < 8 || addr_width > 32) begin : g_bad_width
    $error("addr_width out of range");
  end

  // ==========================================
  // Four-colour attribute state
  logic fc_active; // Four-colour on in this row
  // Row start clears before any new attribute write;
  // a write in the same cycle as a row start is lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fc_active <= 1'b0;
    end else if (row_start) begin
      fc_active <= 1'b0; // R2
    end else if (color_mode_wr) begin
      fc_active <= color_mode_bit; // R1
    end
  end

  // ==========================================
  // Glyph plane addressing for teletext characters
  // Even codes pair with the next glyph, odd codes
  // pair with themselves; a colour mode write in the
  // take cycle applies to that very character
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      glyph_a_code <= 10'h000;
      glyph_b_code <= 10'h000;
      four_colour <= 1'b0;
    end else if (row_start) begin
      four_colour <= 1'b0; // R2
    end else if (char_take) begin
      glyph_a_code <= ttx_char_code;
      four_colour <= color_mode_wr ? color_mode_bit : fc_active; // R3
      if (!ttx_char_code[0]) begin
        glyph_b_code <= ttx_char_code + 10'h001; // R5
      end else begin
        glyph_b_code <= ttx_char_code; // R6
      end
    end
  end

  // ==========================================
  // Pixel colour path
  logic [3:0] fc_code; // Combined colour code
  logic fc_is_fg; // Foreground from first plane
  logic [3:0] sel_code; // Code after layer priority
  logic [clut_colour_bits-1:0] lut_colour; // Looked-up colour
  logic [3:0] osd_code; // Overlay colour code

  // Teletext pixel colour, two or four colours
  four_colour_pixel u_fc (
    .four_colour(four_colour),
    .plane_a(plane_a),
    .plane_b(plane_b),
    .fg_code(ttx_fg),
    .bg_code(ttx_bg),
    .pix_code(fc_code),
    .pix_is_fg(fc_is_fg)
  );

  // Overlay colour from current fg/bg state
  // Overlay codes use the lower half of the table
  logic [2:0] fg_rgb;
  logic [2:0] bg_rgb;
  assign osd_code = plane_a ? {1'b0, fg_rgb} : {1'b0, bg_rgb};

  // Overlay wins when enabled, drawing and not transparent
  always_comb begin
    if (osd_pix_valid && osd_priority && !transparent) begin
      sel_code = osd_code; // R10
    end else if (ttx_pix_valid) begin
      sel_code = fc_code;
    end else begin
      sel_code = osd_code;
    end
  end

  // Sixteen programmable entries, 12 bits each
  colour_lut u_lut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(clut_wr),
    .wr_index(clut_index),
    .wr_colour(clut_colour),
    .rd_index(sel_code),
    .rd_colour(lut_colour)
  );

  // Registered pixel outputs
  // One cycle from pixel inputs to colour out
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pix_colour <= clut_reset;
      pix_fg <= 1'b0;
    end else begin
      pix_colour <= lut_colour; // R8
      pix_fg <= fc_is_fg; // R7
    end
  end

  // ==========================================
  // Text stream fetch machine
  typedef enum logic [1:0] {
    st_idle,
    st_fetch,
    st_wait_take
  } fetch_e;
  fetch_e state;
  logic ctrl_seen; // Control code preceded this read
  // Requests stay up until a code is read; a control
  // code keeps them up for one more read, so the code
  // after it arrives with no help from the display
  // A second control code in a row ends the read
  // like a character would

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      dma_req <= 1'b0;
      dma_addr <= '0;
      ctrl_seen <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          if (layer_start) begin
            dma_addr <= text_pointer; // R11
            dma_req <= 1'b1; // R9
            ctrl_seen <= 1'b0;
            state <= st_fetch;
          end
        end
        st_fetch: begin
          if (dma_ack) begin
            dma_addr <= dma_addr + 1'b1;
            if (dma_data >= code_ctrl_min && !ctrl_seen) begin
              ctrl_seen <= 1'b1; // R13
            end else if (dma_data == code_end) begin
              dma_req <= 1'b0;
              state <= st_idle;
            end else begin
              ctrl_seen <= 1'b0;
              dma_req <= 1'b0;
              state <= st_wait_take;
            end
          end
        end
        st_wait_take: begin
          if (layer_start) begin
            dma_addr <= text_pointer;
            ctrl_seen <= 1'b0;
            dma_req <= 1'b1;
            state <= st_fetch;
          end else if (char_take) begin
            dma_req <= 1'b1;
            state <= st_fetch;
          end
        end
        // Unused state code: drop the request, go idle
        default: begin
          dma_req <= 1'b0;
          state <= st_idle;
        end
      endcase
    end
  end

  // ==========================================
  // Code decode
  logic [2:0] set_latched; // Latched character set
  logic [2:0] set_once; // One-shot character set
  logic set_once_valid; // One-shot pending
  logic got; // Code read this cycle
  assign got = (state == st_fetch) && dma_ack;

  // Attribute and colour state
  // Plain codes below the glyph range change only
  // the attribute they name, except that 07 also clears
  // shadow and 08 also sets transparent; control codes
  // in colour mode reload all three colour fields
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      underline <= 1'b0;
      flash <= 1'b0;
      italics <= 1'b0;
      transparent <= 1'b0;
      shadow <= 1'b0;
      white_transp <= 1'b0;
      fg_rgb <= fg_reset;
      bg_rgb <= bg_reset;
    end else if (got) begin
      unique case (dma_data)
        code_ul_on: underline <= 1'b1; // R15
        code_ul_off: underline <= 1'b0; // R15
        code_fl_on: flash <= 1'b1; // R15
        code_fl_off: flash <= 1'b0; // R15
        code_it_on: italics <= 1'b1; // R15
        code_it_off: italics <= 1'b0; // R15
        code_transp: begin
          transparent <= 1'b1; // R16
          shadow <= 1'b0;
        end
        code_shadow: begin
          transparent <= 1'b1; // R16
          shadow <= 1'b1;
        end
        default: begin
          if (dma_data >= code_ctrl_min && !osd_mode_charset) begin
            fg_rgb <= dma_data[fg_lsb +: 3]; // R19
            bg_rgb <= dma_data[bg_lsb +: 3]; // R19
            white_transp <= dma_data[white_transp_bit]; // R19
          end
        end
      endcase
    end
  end

  // Character set selection
  // A latched set stays until the next latched code;
  // a one-shot set lasts only until the next code below 80h
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      set_latched <= set_reset;
      set_once <= set_reset;
      set_once_valid <= 1'b0;
    end else if (got) begin
      if (dma_data >= code_ctrl_min && osd_mode_charset) begin // R18
        if (dma_data[latch_bit]) begin
          set_latched <= dma_data[set_lsb +: 3]; // R20
          set_once_valid <= 1'b0;
        end else begin
          set_once <= dma_data[set_lsb +: 3]; // R21
          set_once_valid <= 1'b1;
        end
      end else if (dma_data < code_ctrl_min) begin
        set_once_valid <= 1'b0; // R21
      end
    end
  end

  // Character and line outputs
  // Pulses last one cycle; codes 00 and 09-0B are
  // read and dropped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      osd_char <= 10'h000;
      osd_char_valid <= 1'b0;
      osd_font <= 1'b0;
      line_end <= 1'b0;
      layer_done <= 1'b0;
    end else begin
      osd_char_valid <= 1'b0;
      line_end <= 1'b0;
      layer_done <= 1'b0;
      if (got && dma_data < code_ctrl_min) begin // R12
        if (dma_data >= code_char_min) begin
          osd_char <= {set_once_valid ? set_once : set_latched,
                       dma_data[6:0]}; // R17
          osd_font <= font_select; // R17
          osd_char_valid <= 1'b1;
        end else if (dma_data == code_cr) begin
          line_end <= 1'b1; // R16
        end else if (dma_data == code_end) begin
          layer_done <= 1'b1; // R16
        end
      end
    end
  end
endmodule // osd_text_and_four_color_attr

//--- rtl/osd_pkg.sv
package osd_pkg;
  // ==========================================
  // Text stream codes
  localparam logic [7:0] code_ctrl_min = 8'h80;
  localparam logic [7:0] code_ul_on = 8'h01;
  localparam logic [7:0] code_ul_off = 8'h02;
  localparam logic [7:0] code_fl_on = 8'h03;
  localparam logic [7:0] code_fl_off = 8'h04;
  localparam logic [7:0] code_it_on = 8'h05;
  localparam logic [7:0] code_it_off = 8'h06;
  localparam logic [7:0] code_transp = 8'h07;
  localparam logic [7:0] code_shadow = 8'h08;
  localparam logic [7:0] code_end = 8'h0C;
  localparam logic [7:0] code_cr = 8'h0D;
  localparam logic [7:0] code_char_min = 8'h0E;
  // ==========================================
  // Control code field positions
  localparam int fg_lsb = 0;
  localparam int bg_lsb = 3;
  localparam int white_transp_bit = 6;
  localparam int latch_bit = 6;
  localparam int set_lsb = 0;
  // ==========================================
  // Four-colour mode
  localparam int flip_bit = 3;
  localparam logic [3:0] flip_mask = 4'h8;
  // ==========================================
  // Reset values
  localparam logic [2:0] fg_reset = 3'h7;
  localparam logic [2:0] bg_reset = 3'h0;
  localparam logic [2:0] set_reset = 3'h0;
  localparam int clut_colour_bits = 12;
  localparam logic [11:0] clut_reset = 12'h000;
endpackage

//--- rtl/four_colour_pixel.sv
`timescale 1ns/1ns
// Four-colour pixel combiner
module four_colour_pixel
  import osd_pkg::*;
(
  input wire logic four_colour,
  input wire logic plane_a,
  input wire logic plane_b,
  input wire logic [3:0] fg_code,
  input wire logic [3:0] bg_code,
  output logic [3:0] pix_code,
  output logic pix_is_fg
);
  // ==========================================
  // Colour allocation
  always_comb begin
    pix_is_fg = plane_a; // R7
    if (!four_colour) begin
      pix_code = plane_a ? fg_code : bg_code;
    end else begin
      unique case ({plane_a, plane_b}) // R4
        2'b00: pix_code = bg_code;
        2'b10: pix_code = fg_code;
        2'b01: pix_code = bg_code ^ flip_mask;
        default: pix_code = fg_code ^ flip_mask;
      endcase
    end
  end
endmodule // four_colour_pixel

//--- rtl/colour_lut.sv
`timescale 1ns/1ns
// Programmable colour lookup table
module colour_lut
  import osd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [3:0] wr_index,
  input wire logic [clut_colour_bits-1:0] wr_colour,
  input wire logic [3:0] rd_index,
  output logic [clut_colour_bits-1:0] rd_colour
);
  logic [clut_colour_bits-1:0] table_mem [16]; // One of 4096 each
  // ==========================================
  // Entry writes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 16; i++) begin
        table_mem[i] <= clut_reset;
      end
    end else if (wr_en) begin
      table_mem[wr_index] <= wr_colour; // R8
    end
  end
  assign rd_colour = table_mem[rd_index];
endmodule // colour_lut

//--- verif/osd_chk.sv
`timescale 1ns/1ns
// ========================================
// Port checks for the overlay text block
module osd_chk
  import osd_pkg::*;
#(
  parameter int addr_width = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic row_start,
  input wire logic color_mode_bit,
  input wire logic color_mode_wr,
  input wire logic char_take,
  input wire logic [addr_width-1:0] text_pointer,
  input wire logic layer_start,
  input wire logic dma_req,
  input wire logic [addr_width-1:0] dma_addr,
  input wire logic dma_ack,
  input wire logic [7:0] dma_data,
  input wire logic layer_done,
  input wire logic [9:0] glyph_a_code,
  input wire logic [9:0] glyph_b_code,
  input wire logic four_colour,
  input wire logic plane_a,
  input wire logic pix_fg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ========================================
  // Four-colour state and glyph pairing
  AST_FOUR_ON: assert property (char_take && color_mode_wr
    && color_mode_bit && !row_start |=> four_colour) else $error("four on");
  AST_ROW_OFF: assert property (row_start |=> !four_colour)
    else $error("row off");
  AST_EVEN: assert property (four_colour && !glyph_a_code[0]
    |-> glyph_b_code == glyph_a_code + 10'h001) else $error("even pair");
  AST_ODD: assert property (four_colour && glyph_a_code[0]
    |-> glyph_b_code == glyph_a_code) else $error("odd pair");
  AST_FG_A: assert property (1'b1 |=> pix_fg == $past(plane_a))
    else $error("fg plane");
  // ========================================
  // Text fetch
  AST_START: assert property (layer_start && !dma_req
    |=> dma_req && dma_addr == $past(text_pointer)) else $error("start");
  AST_STEP: assert property (dma_req && dma_ack
    |=> dma_addr == $past(dma_addr) + 1'b1) else $error("step");
  AST_END: assert property (dma_req && dma_ack
    && dma_data == code_end |=> layer_done ##1 !dma_req) else $error("end");
  COV_FOUR: cover property (four_colour && plane_a);
  COV_CTRL: cover property (dma_ack && dma_data[7]);
  COV_DONE: cover property (layer_done);
endmodule // osd_chk

bind osd_text_and_four_color_attr osd_chk #(.addr_width(addr_width))
  chk (.*);

//--- verif/dma_mem.sv
`timescale 1ns/1ns
// ========================================
// Processor memory answering overlay reads
module dma_mem (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic dma_req,
  input wire logic [15:0] dma_addr,
  input wire logic [3:0] delay,
  output logic dma_ack,
  output logic [7:0] dma_data
);
  logic [7:0] store [16]; // Text bytes, loaded by the bench
  logic [3:0] wait_cnt; // Cycles waited on this read
  // One byte per request after delay cycles
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dma_ack <= 1'b0;
      dma_data <= 8'h00;
      wait_cnt <= 4'h0;
    end else if (dma_ack) begin
      // Released: bus shows the inverse
      dma_ack <= 1'b0;
      dma_data <= ~dma_data;
      wait_cnt <= 4'h0;
    end else if (dma_req && wait_cnt >= delay) begin
      dma_ack <= 1'b1;
      dma_data <= store[dma_addr[3:0]];
    end else if (dma_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // dma_mem

//--- verif/osd_text_and_four_color_attr_tb.sv
`timescale 1ns/1ns
// ========================================
// Bench for the overlay text block
module osd_text_and_four_color_attr_tb
  import osd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic row_start = 1'b0;
  logic color_mode_bit = 1'b0;
  logic color_mode_wr = 1'b0;
  logic char_take = 1'b0;
  logic [9:0] ttx_char_code = 10'h000;
  logic [15:0] text_pointer = 16'h1230; // Low nibble 0 hits store[0]
  logic layer_start = 1'b0;
  logic osd_mode_charset = 1'b0;
  logic font_select = 1'b0;
  logic plane_a = 1'b0;
  logic plane_b = 1'b0;
  logic [3:0] ttx_fg = 4'h2;
  logic [3:0] ttx_bg = 4'h5;
  logic ttx_pix_valid = 1'b1;
  logic osd_pix_valid = 1'b0;
  logic osd_priority = 1'b0;
  logic clut_wr = 1'b0;
  logic [3:0] clut_index = 4'h0;
  logic [clut_colour_bits-1:0] clut_colour = 12'h000;
  logic [3:0] delay = 4'h0;
  logic dma_req, dma_ack, osd_char_valid, osd_font, underline, flash;
  logic italics, transparent, shadow, white_transp, line_end, layer_done;
  logic four_colour, pix_fg;
  logic [15:0] dma_addr;
  logic [7:0] dma_data;
  logic [9:0] osd_char, glyph_a_code, glyph_b_code;
  logic [clut_colour_bits-1:0] pix_colour;
  logic saw_cr = 1'b0;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  osd_text_and_four_color_attr #(.addr_width(16)) uut (.*);
  dma_mem mem (.*);
  always #25 clk_sys = ~clk_sys;
  // Cycle ceiling and end-of-line watch
  always @(posedge clk_sys) begin
    cycles++;
    if (line_end === 1'b1) saw_cr = 1'b1;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end
  // ========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [11:0] lut(input logic [3:0] i);
    return {i, ~i, i};
  endfunction
  task automatic pix(input logic a, b, pv, pr, input logic [3:0] code);
    @(posedge clk_sys);
    plane_a <= a;
    plane_b <= b;
    osd_pix_valid <= pv;
    osd_priority <= pr;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check(pix_colour, lut(code));
    check(pix_fg, a);
  endtask
  task automatic ttx_take(input logic [9:0] code, input logic wr, bv);
    @(posedge clk_sys);
    char_take <= 1'b1;
    ttx_char_code <= code;
    color_mode_wr <= wr;
    color_mode_bit <= bv;
    @(posedge clk_sys);
    char_take <= 1'b0;
    color_mode_wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic run(input logic [127:0] s, input logic m, f, input int d);
    for (int i = 0; i < 16; i++) mem.store[i] = s[127-8*i -: 8];
    @(posedge clk_sys);
    osd_mode_charset <= m;
    font_select <= f;
    delay <= d[3:0];
    layer_start <= 1'b1;
    @(posedge clk_sys);
    layer_start <= 1'b0;
  endtask
  task automatic get_char(input logic [9:0] exp);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (osd_char_valid !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check(osd_char_valid, 1'b1);
    check(osd_char, exp);
    check(osd_font, font_select);
    @(posedge clk_sys);
    char_take <= 1'b1;
    @(posedge clk_sys);
    char_take <= 1'b0;
  endtask
  // Attribute and line codes also wait for an advance
  task automatic skip_code();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (dma_req !== 1'b0 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check(dma_req, 1'b0);
    check(osd_char_valid, 1'b0);
    @(posedge clk_sys);
    char_take <= 1'b1;
    @(posedge clk_sys);
    char_take <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (layer_done !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check(layer_done, 1'b1);
  endtask
  // ========================================
  // Scenarios
  task automatic test_four();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      clut_wr <= 1'b1;
      clut_index <= i[3:0];
      clut_colour <= lut(i[3:0]);
    end
    @(posedge clk_sys);
    clut_wr <= 1'b0;
    ttx_take(10'h0A4, 1'b1, 1'b1);
    check(four_colour, 1'b1);
    check(glyph_b_code, 10'h0A5);
    pix(0, 0, 0, 0, 4'h5);
    pix(1, 0, 0, 0, 4'h2);
    pix(0, 1, 0, 0, 4'hD);
    pix(1, 1, 0, 0, 4'hA);
    ttx_take(10'h0B7, 1'b0, 1'b1);
    check(glyph_b_code, 10'h0B7);
    check(four_colour, 1'b1);
    @(posedge clk_sys);
    row_start <= 1'b1;
    @(posedge clk_sys);
    row_start <= 1'b0;
    @(negedge clk_sys);
    check(four_colour, 1'b0);
    pix(1, 1, 0, 0, 4'h2);
    ttx_take(10'h0A4, 1'b1, 1'b0);
    check(four_colour, 1'b0);
    $display("Four-colour test done");
  endtask
  task automatic test_colour();
    run(128'hA341_0103_050E_0204_0643_0D7F_0C00_0000, 0, 0, 0);
    get_char(10'h041);
    repeat (3) skip_code();
    get_char(10'h00E);
    check({underline, flash, italics}, 3'h7);
    repeat (3) skip_code();
    get_char(10'h043);
    check({underline, flash, italics}, 3'h0);
    skip_code();
    check(saw_cr, 1'b1);
    get_char(10'h07F);
    wait_done();
    pix(1, 0, 1, 1, 4'h3);
    pix(0, 0, 1, 1, 4'h4);
    pix(1, 0, 1, 0, 4'h2);
    $display("Colour code test done");
  endtask
  task automatic test_set();
    run(128'hC541_4282_4344_C045_0C00_0000_0000_0000, 1, 1, 3);
    get_char(10'h2C1);
    get_char(10'h2C2);
    get_char(10'h143);
    get_char(10'h2C4);
    get_char(10'h045);
    wait_done();
    $display("Character set test done");
  endtask
  task automatic test_attr();
    run(128'hE344_0745_0846_0C00_0000_0000_0000_0000, 0, 0, 1);
    get_char(10'h044);
    check(white_transp, 1'b1);
    skip_code();
    get_char(10'h045);
    check(transparent, 1'b1);
    check(shadow, 1'b0);
    skip_code();
    get_char(10'h046);
    check(shadow, 1'b1);
    wait_done();
    $display("Attribute test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    test_four();
    test_colour();
    test_set();
    test_attr();
    conclude();
  end
endmodule // osd_text_and_four_color_attr_tb
